// ===== rtl/cfg_startup_pkg.sv
// shared constants, field layouts and types for the startup sequencer
package cfg_startup_pkg;

  // register byte offsets
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // config word field positions
  localparam int RATE_POS = 0;
  localparam int SRC_POS = 4;
  localparam int DONE_POS = 8;
  localparam int GWE_POS = 12;
  localparam int GTS_POS = 16;
  localparam int PIPE_POS = 20;
  localparam int EXT_POS = 24;

  // control and status field positions
  localparam int CTRL_LOAD_POS = 0;
  localparam int ST_PHASE_POS = 0;
  localparam int ST_GWE_POS = 4;
  localparam int ST_GTS_POS = 5;
  localparam int ST_GSR_POS = 6;
  localparam int ST_DONE_REL_POS = 7;
  localparam int ST_DONE_IN_POS = 8;
  localparam int ST_STATE_POS = 12;
  localparam int ST_RATE_POS = 16;

  // phase codes: 1..6 are startup phases
  localparam logic [2:0] PH_KEEP = 3'h0;
  localparam logic [2:0] PH_FOLLOW = 3'h7;
  localparam logic [2:0] PH_END = 3'h7;
  localparam logic [2:0] PH_ZERO = 3'h0;

  // reset values
  localparam logic [2:0] RATE_RESET = 3'h0;
  localparam logic [2:0] DONE_PHASE_RESET = 3'h4;
  localparam logic [2:0] GWE_PHASE_RESET = 3'h6;
  localparam logic [2:0] GTS_PHASE_RESET = 3'h5;

  // oscillator rates in kHz, index 0 is the slowest setting (nominal 1)
  localparam int CLK_SYS_KHZ = 200000;
  localparam int OSC_KHZ [0:5] = '{1500, 3000, 6000, 12000, 25000, 50000};

  typedef enum logic [1:0] {SRC_CCLK, SRC_FABRIC, SRC_TEST} clk_src_e;
  typedef enum logic [1:0] {ST_CONFIG, ST_STARTUP, ST_USER} seq_state_e;

  typedef struct packed {
    logic [2:0] rate_idx;
    clk_src_e clk_src;
    logic [2:0] done_phase;
    logic [2:0] gwe_sel;
    logic [2:0] gts_sel;
    logic done_pipe;
    logic ext_cclk;
  } cfg_s;

  localparam cfg_s CFG_RESET = '{RATE_RESET, SRC_CCLK, DONE_PHASE_RESET,
                                 GWE_PHASE_RESET, GTS_PHASE_RESET, 1'b0, 1'b0};

  // half period of the oscillator in system cycles, rounded down
  function automatic logic [7:0] half_period(input logic [2:0] idx);
    int khz;
    khz = (idx > 3'h5) ? OSC_KHZ[0] : OSC_KHZ[idx];
    half_period = 8'(CLK_SYS_KHZ / (2 * khz));
  endfunction : half_period

  function automatic cfg_s cfg_from_word(input logic [31:0] w);
    cfg_s c;
    c.rate_idx = w[RATE_POS +: 3];
    c.clk_src = clk_src_e'(w[SRC_POS +: 2]);
    c.done_phase = w[DONE_POS +: 3];
    c.gwe_sel = w[GWE_POS +: 3];
    c.gts_sel = w[GTS_POS +: 3];
    c.done_pipe = w[PIPE_POS];
    c.ext_cclk = w[EXT_POS];
    return c;
  endfunction : cfg_from_word

  function automatic logic [31:0] cfg_to_word(input cfg_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[RATE_POS +: 3] = c.rate_idx;
    w[SRC_POS +: 2] = c.clk_src;
    w[DONE_POS +: 3] = c.done_phase;
    w[GWE_POS +: 3] = c.gwe_sel;
    w[GTS_POS +: 3] = c.gts_sel;
    w[PIPE_POS] = c.done_pipe;
    w[EXT_POS] = c.ext_cclk;
    return w;
  endfunction : cfg_to_word

endpackage : cfg_startup_pkg

// ===== rtl/level_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : level_sync

// ===== rtl/cfg_oscillator.sv
// configuration oscillator: divider with selectable rate and rising-edge tick
`timescale 1ns/1ps
module cfg_oscillator (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] rate_idx,
  output logic tick,
  output logic osc_clk
);
  logic [7:0] cnt_q;
  logic [7:0] half;

  assign half = cfg_startup_pkg::half_period(rate_idx);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      osc_clk <= 1'b0;
      tick <= 1'b0;
    end else if (cnt_q >= half - 8'h01) begin
      cnt_q <= 8'h00;
      osc_clk <= !osc_clk;
      tick <= !osc_clk;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule : cfg_oscillator

// ===== rtl/config_startup_sequencer.sv
// startup sequencer with APB option registers and phase-driven global controls
`timescale 1ns/1ps
// What this block does
// - oscillator rates 1, 3, 6, 12, 25, 50 MHz
// - slowest rate until setting is loaded
// - default rate setting 1, about 1.5 MHz
// - configuration clock drives startup by default
// - fabric clock option advances on fabric clock
// - test clock option advances on test clock
// - completion pin released in phase 1-6, default 4
// - write enable in phase 1-6, default 6
// - follow option waits for completion input high
// - keep option retains write-enable phase setting
// - outputs high impedance until phase, default 5
// - follow option holds tristate until completion high
// - optional pipeline stage on completion input
// - set/reset held during config, released at first startup edge
module config_startup_sequencer (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CCLK_IN,
  input wire logic FABRIC_CLK,
  input wire logic TCK,
  input wire logic DONE_I,
  output logic CCLK_OUT,
  output logic DONE_O,
  output logic DONE_OE,
  output logic GLOBAL_SET_RESET,
  output logic GLOBAL_WRITE_ENABLE,
  output logic GLOBAL_TRISTATE
);

  cfg_startup_pkg::cfg_s cfg_q;
  cfg_startup_pkg::seq_state_e state_q;
  cfg_startup_pkg::clk_src_e src_eff_q;
  logic [2:0] rate_eff_q;
  logic [2:0] done_eff_q;
  logic [2:0] gwe_eff_q;
  logic [2:0] gts_eff_q;
  logic pipe_eff_q;
  logic [2:0] phase_q;
  logic [3:0] pin_sync;
  logic [2:0] clk_prev_q;
  logic [2:0] clk_rise;
  logic osc_tick;
  logic cclk_rise;
  logic adv;
  logic done_sync;
  logic pipe_q;
  logic done_ok;
  logic access;
  logic wr_en;
  logic load;
  logic started;
  logic [31:0] rd_word;
  logic addr_ok;

  // release test shared by write enable and tristate
  function automatic logic release_due(input logic [2:0] sel, input logic [2:0] ph,
                                       input logic ok, input logic edge_now);
    if (sel == cfg_startup_pkg::PH_FOLLOW) begin
      release_due = ok && edge_now;
    end else begin
      release_due = (ph >= sel);
    end
  endfunction : release_due

  // pins from outside pass two flops
  level_sync #(.W(4)) u_sync (
    .clk(CLK_SYS),
    .nrst(NRST),
    .din({DONE_I, TCK, FABRIC_CLK, CCLK_IN}),
    .dout(pin_sync)
  );

  cfg_oscillator u_osc (
    .clk(CLK_SYS),
    .nrst(NRST),
    .rate_idx(rate_eff_q),
    .tick(osc_tick),
    .osc_clk(CCLK_OUT)
  );

  assign done_sync = pin_sync[3];
  assign clk_rise = pin_sync[2:0] & ~clk_prev_q;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      clk_prev_q <= 3'h0;
    end else begin
      clk_prev_q <= pin_sync[2:0];
    end
  end

  // startup clock selection
  assign cclk_rise = cfg_q.ext_cclk ? clk_rise[0] : osc_tick;
  always_comb begin
    unique case (src_eff_q)
      cfg_startup_pkg::SRC_FABRIC: adv = clk_rise[1];
      cfg_startup_pkg::SRC_TEST: adv = clk_rise[2];
      default: adv = cclk_rise;
    endcase
  end

  // apb slave: one wait state, ready from a flop
  assign access = PSEL && PENABLE;
  assign wr_en = access && PREADY && PWRITE;
  assign load = wr_en && (PADDR == cfg_startup_pkg::ADDR_CONTROL) &&
                PWDATA[cfg_startup_pkg::CTRL_LOAD_POS];
  assign started = (state_q == cfg_startup_pkg::ST_STARTUP);
  assign addr_ok = (PADDR == cfg_startup_pkg::ADDR_CONFIG) ||
                   (PADDR == cfg_startup_pkg::ADDR_CONTROL) ||
                   (PADDR == cfg_startup_pkg::ADDR_STATUS);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (PADDR == cfg_startup_pkg::ADDR_CONFIG) begin
      rd_word = cfg_startup_pkg::cfg_to_word(cfg_q);
    end else if (PADDR == cfg_startup_pkg::ADDR_STATUS) begin
      rd_word[cfg_startup_pkg::ST_PHASE_POS +: 3] = phase_q;
      rd_word[cfg_startup_pkg::ST_GWE_POS] = GLOBAL_WRITE_ENABLE;
      rd_word[cfg_startup_pkg::ST_GTS_POS] = GLOBAL_TRISTATE;
      rd_word[cfg_startup_pkg::ST_GSR_POS] = GLOBAL_SET_RESET;
      rd_word[cfg_startup_pkg::ST_DONE_REL_POS] = !DONE_OE;
      rd_word[cfg_startup_pkg::ST_DONE_IN_POS] = done_sync;
      rd_word[cfg_startup_pkg::ST_STATE_POS +: 2] = state_q;
      rd_word[cfg_startup_pkg::ST_RATE_POS +: 3] = rate_eff_q;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (access && !PREADY) begin
      PREADY <= 1'b1;
      PRDATA <= PWRITE ? 32'h0000_0000 : rd_word;
      PSLVERR <= !addr_ok;
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // option register
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cfg_q <= cfg_startup_pkg::CFG_RESET;
    end else if (wr_en && (PADDR == cfg_startup_pkg::ADDR_CONFIG)) begin
      cfg_q <= cfg_startup_pkg::cfg_from_word(PWDATA);
    end
  end

  // settings in effect, taken when the image is loaded
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rate_eff_q <= cfg_startup_pkg::RATE_RESET;
      src_eff_q <= cfg_startup_pkg::SRC_CCLK;
      done_eff_q <= cfg_startup_pkg::DONE_PHASE_RESET;
      gwe_eff_q <= cfg_startup_pkg::GWE_PHASE_RESET;
      gts_eff_q <= cfg_startup_pkg::GTS_PHASE_RESET;
      pipe_eff_q <= 1'b0;
    end else if (load && (state_q != cfg_startup_pkg::ST_STARTUP)) begin
      rate_eff_q <= cfg_q.rate_idx;
      src_eff_q <= cfg_q.clk_src;
      done_eff_q <= cfg_q.done_phase;
      pipe_eff_q <= cfg_q.done_pipe;
      if (cfg_q.gwe_sel != cfg_startup_pkg::PH_KEEP) begin
        gwe_eff_q <= cfg_q.gwe_sel;
      end
      if (cfg_q.gts_sel != cfg_startup_pkg::PH_KEEP) begin
        gts_eff_q <= cfg_q.gts_sel;
      end
    end
  end

  // sequencer state and phase counter
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state_q <= cfg_startup_pkg::ST_CONFIG;
      phase_q <= cfg_startup_pkg::PH_ZERO;
    end else begin
      unique case (state_q)
        cfg_startup_pkg::ST_CONFIG: begin
          if (load) begin
            state_q <= cfg_startup_pkg::ST_STARTUP;
            phase_q <= cfg_startup_pkg::PH_ZERO;
          end
        end
        cfg_startup_pkg::ST_STARTUP: begin
          if (adv) begin
            phase_q <= phase_q + 3'h1;
            if (phase_q + 3'h1 == cfg_startup_pkg::PH_END) begin
              state_q <= cfg_startup_pkg::ST_USER;
            end
          end
        end
        default: state_q <= cfg_startup_pkg::ST_USER;
      endcase
    end
  end

  // completion input, optionally pipelined on the startup clock
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      pipe_q <= 1'b0;
    end else if (adv) begin
      pipe_q <= done_sync;
    end
  end
  assign done_ok = pipe_eff_q ? pipe_q : done_sync;

  // completion pin, open drain, driven low until its phase
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      DONE_O <= 1'b0;
      DONE_OE <= 1'b1;
    end else if (started && (phase_q >= done_eff_q)) begin
      DONE_OE <= 1'b0;
    end
  end

  // global set/reset held through configuration, dropped at first startup edge
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      GLOBAL_SET_RESET <= 1'b1;
    end else if (started && adv) begin
      GLOBAL_SET_RESET <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      GLOBAL_WRITE_ENABLE <= 1'b0;
    end else if (state_q != cfg_startup_pkg::ST_CONFIG &&
                 release_due(gwe_eff_q, phase_q, done_ok, adv)) begin
      GLOBAL_WRITE_ENABLE <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      GLOBAL_TRISTATE <= 1'b1;
    end else if (state_q != cfg_startup_pkg::ST_CONFIG &&
                 release_due(gts_eff_q, phase_q, done_ok, adv)) begin
      GLOBAL_TRISTATE <= 1'b0;
    end
  end

  // checks
  chk_rate_before_load: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (state_q == cfg_startup_pkg::ST_CONFIG) |-> (rate_eff_q == cfg_startup_pkg::RATE_RESET))
    else $error("oscillator left slowest rate before load");

  chk_phase_step: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (started && adv) |=> (phase_q == $past(phase_q) + 3'h1))
    else $error("phase did not advance on startup edge");

  chk_phase_hold: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (started && !adv) |=> $stable(phase_q))
    else $error("phase moved without startup edge");

  chk_set_reset_config: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (state_q == cfg_startup_pkg::ST_CONFIG) |-> GLOBAL_SET_RESET && GLOBAL_TRISTATE &&
    !GLOBAL_WRITE_ENABLE)
    else $error("globals not held during configuration");

  chk_done_release: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (started && phase_q >= done_eff_q) |=> !DONE_OE)
    else $error("completion pin not released in its phase");

  chk_done_early: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    $fell(DONE_OE) |-> $past(phase_q) >= done_eff_q)
    else $error("completion pin released early");

  chk_write_follow: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (gwe_eff_q == cfg_startup_pkg::PH_FOLLOW && !done_ok) |=> !$rose(GLOBAL_WRITE_ENABLE))
    else $error("write enable rose before completion input");

  chk_write_phase: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    $rose(GLOBAL_WRITE_ENABLE) && gwe_eff_q != cfg_startup_pkg::PH_FOLLOW |->
    $past(phase_q) >= gwe_eff_q)
    else $error("write enable before its phase");

  chk_tristate_phase: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    $fell(GLOBAL_TRISTATE) && gts_eff_q != cfg_startup_pkg::PH_FOLLOW |->
    $past(phase_q) >= gts_eff_q)
    else $error("outputs released before their phase");

  chk_tristate_follow: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    $fell(GLOBAL_TRISTATE) && gts_eff_q == cfg_startup_pkg::PH_FOLLOW |->
    $past(done_ok) && $past(adv))
    else $error("outputs released without completion input");

  chk_keep_setting: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (load && cfg_q.gwe_sel == cfg_startup_pkg::PH_KEEP) |=> $stable(gwe_eff_q))
    else $error("keep option changed write-enable phase");

  chk_apb_ready: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (access && !PREADY) |=> PREADY ##1 !PREADY)
    else $error("bus answer not one wait state");

endmodule : config_startup_sequencer

// ===== testbench/done_pin_partner.sv
// other devices on the open-drain completion pin, with pull-up
`timescale 1ns/1ps
module done_pin_partner (
  input wire logic done_o,
  input wire logic done_oe,
  input wire logic hold_low,
  output logic done_wire
);
  // wired-and of all drivers; the pull-up gives high when nobody pulls low
  assign done_wire = ((done_oe && !done_o) || hold_low) ? 1'b0 : 1'b1;
endmodule : done_pin_partner

// ===== testbench/test_config_startup_sequencer.sv
// self-checking bench for the startup sequencer
`timescale 1ns/1ps
module test_config_startup_sequencer;
  logic clk, nrst, psel, pen, pwr, cclk, fclk, tck, hold, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, cclk_out, done_o, done_oe, global_set_reset, global_write_enable, global_tristate, done_w;
  int mismatches, checks_done;

  config_startup_sequencer dut (.CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CCLK_IN(cclk), .FABRIC_CLK(fclk), .TCK(tck), .DONE_I(done_w),
    .CCLK_OUT(cclk_out), .DONE_O(done_o), .DONE_OE(done_oe), .GLOBAL_SET_RESET(global_set_reset),
    .GLOBAL_WRITE_ENABLE(global_write_enable), .GLOBAL_TRISTATE(global_tristate));

  done_pin_partner partner (.done_o(done_o), .done_oe(done_oe), .hold_low(hold),
    .done_wire(done_w));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1, "no pready");
  endtask : apb

  task automatic rst;
    nrst <= 1'b0;
    hold <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask : rst

  // one full cycle of a single startup clock, the others stay still
  task automatic edge_on(input logic [1:0] s);
    @(posedge clk);
    case (s)
      2'h1: fclk <= 1'b1;
      2'h2: tck <= 1'b1;
      default: cclk <= 1'b1;
    endcase
    repeat (8) @(posedge clk);
    {cclk, fclk, tck} <= 3'h0;
    repeat (8) @(posedge clk);
  endtask : edge_on

  task automatic meas(output int n);
    logic p;
    int t;
    t = 0;
    n = 0;
    p = cclk_out;
    while (cclk_out === p && t < 300) begin
      @(posedge clk);
      t++;
    end
    p = cclk_out;
    while (cclk_out === p && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask : meas

  task automatic run(input logic [31:0] word, input int pd, input int pw, input int pt,
                     input int half);
    logic [1:0] s;
    int n;
    s = word[5:4];
    rst();
    apb(1'b0, cfg_startup_pkg::ADDR_CONFIG, 32'h0);
    chk(rd, 32'h0005_6400, "config reset");
    apb(1'b0, cfg_startup_pkg::ADDR_STATUS, 32'h0);
    chk({rd[18:16], rd[13:12], rd[6:4]}, 8'h06, "status reset");
    chk({done_oe, global_set_reset, global_write_enable, global_tristate}, 4'hD, "outputs reset");
    apb(1'b1, cfg_startup_pkg::ADDR_CONFIG, word);
    apb(1'b0, cfg_startup_pkg::ADDR_CONFIG, 32'h0);
    chk(rd, word, "config readback");
    if (half != 0) begin
      meas(n);
      chk(n, 66, "rate before load");
    end
    edge_on(s);
    apb(1'b0, cfg_startup_pkg::ADDR_STATUS, 32'h0);
    chk(rd[2:0], 3'h0, "advance before load");
    apb(1'b1, cfg_startup_pkg::ADDR_CONTROL, 32'h1);
    edge_on((s == 2'h2) ? 2'h0 : s + 2'h1);
    apb(1'b0, cfg_startup_pkg::ADDR_STATUS, 32'h0);
    chk({rd[6], rd[2:0]}, 4'h8, "wrong clock advanced");
    if (half != 0) begin
      meas(n);
      chk(n, half, "rate after load");
      chk(rd[18:16], word[2:0], "effective rate");
    end
    for (int k = 1; k <= 8; k++) begin
      edge_on(s);
      apb(1'b0, cfg_startup_pkg::ADDR_STATUS, 32'h0);
      chk(rd[2:0], (k > 7) ? 3'h7 : 3'(k), "phase");
      chk(done_oe, k < pd, "completion release");
      chk(global_tristate, k < pt, "tristate");
      chk(global_write_enable, k >= pw, "write enable");
      chk({global_set_reset, done_o}, 2'h0, "set reset");
    end
    $display("test run %h done", word);
  endtask : run

  task automatic follow(input logic pipe);
    rst();
    hold <= 1'b1;
    apb(1'b1, cfg_startup_pkg::ADDR_CONFIG, 32'h0007_7210 | (32'(pipe) << 20));
    apb(1'b1, cfg_startup_pkg::ADDR_CONTROL, 32'h1);
    repeat (7) edge_on(2'h1);
    chk({done_oe, global_write_enable, global_tristate}, 3'h1, "held by pin low");
    hold <= 1'b0;
    repeat (8) @(posedge clk);
    edge_on(2'h1);
    chk({global_write_enable, global_tristate}, pipe ? 2'h1 : 2'h2, "first edge after high");
    edge_on(2'h1);
    chk({global_write_enable, global_tristate}, 2'h2, "second edge after high");
    $display("test follow pipe %0d done", pipe);
  endtask : follow

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {nrst, psel, pen, pwr, cclk, fclk, tck, hold} = 8'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mismatches = 0;
    checks_done = 0;
    run(32'h0102_6100, 1, 6, 2, 0);
    run(32'h0005_6415, 4, 6, 5, cfg_startup_pkg::CLK_SYS_KHZ / 100000);
    run(32'h0001_3623, 6, 3, 1, cfg_startup_pkg::CLK_SYS_KHZ / 24000);
    run(32'h0000_0322, 3, 6, 5, cfg_startup_pkg::CLK_SYS_KHZ / 12000);
    // internal oscillator as startup clock, fastest rate, free running
    rst();
    apb(1'b1, cfg_startup_pkg::ADDR_CONFIG, 32'h0005_6405);
    apb(1'b1, cfg_startup_pkg::ADDR_CONTROL, 32'h1);
    repeat (40) @(posedge clk);
    apb(1'b0, cfg_startup_pkg::ADDR_STATUS, 32'h0);
    chk({rd[13:12], rd[2:0]}, 5'h17, "internal clock startup");
    chk({done_oe, global_write_enable, global_tristate}, 3'h2, "internal clock outputs");
    $display("test internal clock done");
    follow(1'b0);
    follow(1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b0, cfg_startup_pkg::ADDR_CONTROL, 32'h0);
    chk(rd, 32'h0, "control reads zero");
    $display("test registers done");
    tally_and_finish();
  end
endmodule : test_config_startup_sequencer
